// >>> bench/fault_recovery_relay_control_test.sv
`timescale 1ns/1ns
module fault_recovery_relay_control_test;
  typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [11:0] x; logic e;}
    frr_row_t;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic        sys_error = 1'h0, rdi = 1'h0, seq_val = 1'h0, pw = 1'h0, hv = 1'h0;
  logic [3:0]  pl = 4'h0;
  logic [5:0]  fault_in = 6'h0;
  logic [11:0] paddr = 12'h0, display_code;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, er, cc_mode, relay_on, output_enable, setpoint_mode;
  logic        auto_warning;
  integer      fail_count = 0, tests_run = 0, n, t;
  frr_row_t    rows [0:10] = '{
    '{1'h1, 12'h004, 32'h0, 12'h0, 1'h1}, '{1'h1, 12'h004, 32'h101, 12'h0, 1'h1},
    '{1'h1, 12'h004, 32'h100, 12'h0, 1'h0}, '{1'h0, 12'h004, 32'h0, 12'h100, 1'h0},
    '{1'h1, 12'h004, 32'h1, 12'h0, 1'h0}, '{1'h0, 12'h004, 32'h0, 12'h001, 1'h0},
    '{1'h1, 12'h008, 32'h1, 12'h0, 1'h1}, '{1'h0, 12'h018, 32'h0, 12'h0, 1'h1},
    '{1'h1, 12'h000, 32'h3, 12'h0, 1'h0}, '{1'h0, 12'h000, 32'h0, 12'h020, 1'h0},
    '{1'h1, 12'h004, 32'h2, 12'h0, 1'h0}};

  frr_ctrl #(.HALF_CYC(4), .WARN_CYC(8), .BRIEF_CYC(4)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fault_in(fault_in), .sys_error(sys_error), .cc_mode(cc_mode), .out_on_req(pl[0]),
    .setpoint_exit(pl[1]), .remote_disable_input(rdi), .seq_relay_cmd(pl[2]),
    .seq_relay_val(seq_val), .security_clear(pl[3]), .password_ok(pw),
    .relay_on(relay_on), .output_enable(output_enable), .setpoint_mode(setpoint_mode),
    .load_min(), .load_setpoint(), .load_last_actual(), .auto_warning(auto_warning),
    .err_push(), .err_code(), .display_code(display_code));
  frr_plant u_plant (.pclk(pclk), .output_enable(output_enable), .heavy_load(hv),
    .cc_mode(cc_mode));

  initial forever #50 pclk = ~pclk;

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      tests_run = tests_run + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("BAD %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  function logic sg(input integer k);
    case (k)
      0: sg = relay_on;
      1: sg = output_enable;
      2: sg = cc_mode;
      default: sg = auto_warning;
    endcase
  endfunction
  // every wait is bounded; running out ends the run
  task wt(input integer k, input logic v, output integer c);
    begin
      c = 0;
      tests_run = tests_run + 1;
      while (sg(k) !== v && c < 60) begin
        @(posedge pclk);
        c = c + 1;
      end
      if (sg(k) !== v) begin
        fail_count = fail_count + 1;
        $display("BAD wait %0d exp %h got %h", k, v, sg(k));
        finish_test;
      end
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer k;
    begin
      @(posedge pclk);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      k = 0;
      do begin
        @(posedge pclk);
        k = k + 1;
      end while (pready !== 1'h1 && k < 20);
      rd = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
      if (k == 20) begin
        chk("pready", 1, 0);
        finish_test;
      end
    end
  endtask
  task pls(input logic [3:0] m);
    begin
      @(posedge pclk);
      pl <= m;
      @(posedge pclk);
      pl <= 4'h0;
    end
  endtask
  task rst;
    begin
      @(posedge pclk);
      presetn <= 1'h0;
      repeat (8) @(posedge pclk);
      presetn <= 1'h1;
      repeat (3) @(posedge pclk);
    end
  endtask
  task on_out;
    begin
      pls(4'h2);
      pls(4'h1);
      wt(1, 1'h1, n);
    end
  endtask

  initial begin
    rst;
    pw <= 1'h1;
    // store is blank on the first pass, so settle it and power up again
    apb(1'h1, 12'h000, 32'h20);
    apb(1'h1, 12'h004, 32'h2);
    apb(1'h1, 12'h008, 32'h0);
    rst;
    chk("relay_boot", 0, relay_on);
    pw <= 1'h0;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("slverr", rows[i].e, er);
      if (!rows[i].w && !rows[i].e) chk("rdata", rows[i].x, rd & 32'hFFF);
    end
    pw <= 1'h1;
    apb(1'h1, 12'h000, 32'h25);
    pls(4'h8);
    apb(1'h0, 12'h000, 32'h0);
    chk("clear", 32'h0, rd & 32'hF);
    on_out;
    rdi <= 1'h1;
    wt(1, 1'h0, n);
    repeat (3) @(posedge pclk);
    rdi <= 1'h0;
    on_out;
    for (t = 1; t < 3; t = t + 1) begin
      apb(1'h1, 12'h000, 32'h20 | (t << 2));
      hv <= (t == 2);
      wt(2, t == 2, n);
      repeat (12) @(posedge pclk);
      chk("no_trip", 0, relay_on);
      hv <= (t != 2);
      wt(2, t != 2, n);
      repeat (3) @(posedge pclk);
      hv <= (t == 2);
      wt(2, t == 2, n);
      hv <= (t != 2);
      wt(2, t != 2, n);
      wt(0, 1'h1, n);
      chk("dwell", 1, n > 6 && n < 12);
      chk("disp", 32'h302, display_code);
      hv <= (t == 2);
      wt(0, 1'h0, n);
    end
    hv <= 1'h0;
    apb(1'h1, 12'h000, 32'h21);
    apb(1'h1, 12'h00C, 32'h3);
    wt(0, 1'h1, n);
    apb(1'h1, 12'h00C, 32'h1);
    wt(0, 1'h0, n);
    apb(1'h1, 12'h000, 32'h22);
    apb(1'h1, 12'h00C, 32'h3);
    repeat (4) @(posedge pclk);
    chk("seq_only", 0, relay_on);
    seq_val <= 1'h1;
    pls(4'h4);
    wt(0, 1'h1, n);
    seq_val <= 1'h0;
    pls(4'h4);
    wt(0, 1'h0, n);
    apb(1'h1, 12'h000, 32'h20);
    sys_error <= 1'h1;
    wt(0, 1'h1, n);
    sys_error <= 1'h0;
    apb(1'h1, 12'h008, 32'h1);
    fault_in <= 6'h01;
    wt(1, 1'h0, n);
    fault_in <= 6'h00;
    rdi <= 1'h1;
    repeat (4) @(posedge pclk);
    rdi <= 1'h0;
    repeat (6) @(posedge pclk);
    chk("guard_oe", 0, output_enable);
    chk("guard_sp", 1, setpoint_mode);
    on_out;
    apb(1'h1, 12'h008, 32'h81);
    fault_in <= 6'h09;
    wt(1, 1'h0, n);
    fault_in <= 6'h00;
    repeat (10) @(posedge pclk);
    chk("multi", 0, output_enable);
    on_out;
    fault_in <= 6'h08;
    wt(1, 1'h0, n);
    fault_in <= 6'h00;
    wt(1, 1'h1, n);
    wt(3, 1'h1, n);
    apb(1'h1, 12'h008, 32'hAAA);
    apb(1'h0, 12'h008, 32'h0);
    // lead, ov, oc fall back to protected; fan stays protected
    chk("clamp", 32'h280, rd & 32'hFFF);
    fault_in <= 6'h20;
    wt(1, 1'h0, n);
    fault_in <= 6'h00;
    pls(4'h2);
    pls(4'h1);
    repeat (10) @(posedge pclk);
    chk("protected_recovery", 0, output_enable);
    rst;
    chk("boot_relay", 0, relay_on);
    wt(3, 1'h1, n);
    chk("boot_oe", 0, output_enable);
    apb(1'h0, 12'h004, 32'h0);
    chk("kept", 32'h2, rd);
    finish_test;
  end
endmodule // fault_recovery_relay_control_test

// >>> bench/frr_ctrl_asserts.sv
`timescale 1ns/1ns
module frr_ctrl_asserts (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        password_ok,
  input wire        sys_error,
  input wire        remote_disable_input,
  input wire        seq_relay_cmd,
  input wire        seq_relay_val,
  input wire        relay_on,
  input wire        output_enable,
  input wire        setpoint_mode,
  input wire        load_min,
  input wire        load_setpoint,
  input wire        load_last_actual,
  input wire        err_push,
  input wire [15:0] err_code,
  input wire [11:0] display_code
);
  // shadow of mode and polarity; not reset, like the settings store
  reg  [1:0] mode_q;
  reg        pol_q;
  wire       wr = psel && penable && pwrite && pready;
  always @(posedge pclk) begin
    if (wr && paddr == 12'h000 && pwdata[1:0] != 2'h3) mode_q <= pwdata[1:0];
    if (wr && paddr == 12'h000 && password_ok) pol_q <= pwdata[5];
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_code; err_push |-> err_code == 16'hFED2 ##[0:2] display_code == 12'h302; endproperty
  a_code: assert property (p_code) else $error("transition code wrong");
  property p_dly; wr && paddr == 12'h004 && (pwdata == 32'h0 || pwdata > 32'h100) |-> pslverr;
  endproperty
  a_dly: assert property (p_dly) else $error("bad delay accepted");
  property p_pw; wr && paddr == 12'h008 && !password_ok |-> pslverr; endproperty
  a_pw: assert property (p_pw) else $error("policy written without password");
  property p_sys; mode_q == 2'h0 && sys_error |-> ##[0:2] relay_on; endproperty
  a_sys: assert property (p_sys) else $error("error did not energize relay");
  property p_seq; mode_q == 2'h2 && seq_relay_cmd |-> ##[1:2] relay_on == seq_relay_val;
  endproperty
  a_seq: assert property (p_seq) else $error("relay ignored sequence command");
  property p_inh; (remote_disable_input == pol_q) [*3] |-> !output_enable; endproperty
  a_inh: assert property (p_inh) else $error("output on while inhibited");
  property p_safe; load_setpoint |-> ##[0:1] setpoint_mode && !output_enable; endproperty
  a_safe: assert property (p_safe) else $error("guarded response wrong");
  property p_auto; load_last_actual |-> ##[0:1] output_enable; endproperty
  a_auto: assert property (p_auto) else $error("self recovery left output off");
  property p_boot; load_min |-> setpoint_mode && !output_enable; endproperty
  a_boot: assert property (p_boot) else $error("power-up not safe");
  c_trip: cover property (err_push);
  c_safe: cover property (load_setpoint);
  c_auto: cover property (load_last_actual);
endmodule // frr_ctrl_asserts
bind frr_ctrl frr_ctrl_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .password_ok(password_ok), .sys_error(sys_error),
  .remote_disable_input(remote_disable_input), .seq_relay_cmd(seq_relay_cmd),
  .seq_relay_val(seq_relay_val), .relay_on(relay_on), .output_enable(output_enable),
  .setpoint_mode(setpoint_mode), .load_min(load_min), .load_setpoint(load_setpoint),
  .load_last_actual(load_last_actual), .err_push(err_push), .err_code(err_code),
  .display_code(display_code));

// >>> bench/frr_plant.sv
`timescale 1ns/1ns
module frr_plant (
  input  wire logic pclk,
  input  wire logic output_enable,
  input  wire logic heavy_load,
  output logic      cc_mode = 1'h0
);
  // current limit only bites while the output is on; a dead output sits in cv
  always @(posedge pclk) begin
    cc_mode <= output_enable & heavy_load;
  end
endmodule // frr_plant

// >>> hw/dummy_unused_placeholder.v
`timescale 1ns/1ns

// >>> hw/frr_ctrl.v
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
`include "frr_defs.vh"
module frr_ctrl #(
  parameter HALF_CYC = `FRR_CLK_HZ / 1000 * `FRR_HALF_S_MS,
  parameter WARN_CYC = `FRR_CLK_HZ / 1000 * `FRR_WARN_MS,
  parameter BRIEF_CYC = `FRR_CLK_HZ / 1000 * `FRR_HALF_S_MS
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [5:0]  fault_in,
  input  wire        sys_error,
  input  wire        cc_mode,
  input  wire        out_on_req,
  input  wire        setpoint_exit,
  input  wire        remote_disable_input,
  input  wire        seq_relay_cmd,
  input  wire        seq_relay_val,
  input  wire        security_clear,
  input  wire        password_ok,
  output reg         relay_on,
  output reg         output_enable,
  output reg         setpoint_mode,
  output reg         load_min,
  output reg         load_setpoint,
  output reg         load_last_actual,
  output reg         auto_warning,
  output reg         err_push,
  output reg  [15:0] err_code,
  output reg  [11:0] display_code
);
  // fault bits: 0 ov, 1 oc, 2 lead, 3 temp, 4 supply loss, 5 fan
  localparam ST_BOOT = 2'h0;
  localparam ST_LOAD = 2'h1;
  localparam ST_RUN  = 2'h2;
  reg  [1:0]  st_q;
  reg  [1:0]  rd_idx_q;
  reg  [1:0]  relay_mode_q;
  reg  [1:0]  trig_q;
  reg  [8:0]  delay_q;
  reg         fast_boot_q;
  reg         inh_pol_q;
  reg  [11:0] policy_q;
  reg         panel_relay_q;
  reg         seq_relay_q;
  reg         trip_q;
  reg         prev_cc_q;
  reg         dwell_q;
  reg  [23:0] tick_q;
  reg  [8:0]  halves_q;
  reg         latched_q;
  reg         auto_pend_q;
  reg  [5:0]  fault_prev_q;
  reg  [23:0] warn_cnt_q;
  reg         multi_q;
  reg         nv_slot_q;
  reg         nv_we;
  reg  [1:0]  nv_waddr;
  reg  [31:0] nv_wdata;
  wire [31:0] nv_rdata;
  wire        acc = psel & penable;
  wire        wr  = acc & pwrite;
  wire        inh_active = remote_disable_input ^ ~inh_pol_q;
  wire        any_fault = |fault_in;
  wire        tgt_cc = (trig_q == `FRR_TRIG_V2C);
  wire        in_target = (cc_mode == tgt_cc);
  wire        trans_trig = (trig_q != `FRR_TRIG_FAULT_ONLY_TRIGGER);
  // clamp one policy to what that fault type allows
  function [1:0] legal_pol;
    input [1:0] p;
    input [2:0] idx;
    begin
      if (idx == 3'd5) begin
        legal_pol = `FRR_POL_PROTECTED_RECOVERY;
      end else if (idx < 3'd3) begin
        legal_pol = (p == `FRR_POL_SAFE) ? `FRR_POL_SAFE : `FRR_POL_PROTECTED_RECOVERY;
      end else begin
        legal_pol = (p > `FRR_POL_AUTO) ? `FRR_POL_PROTECTED_RECOVERY : p;
      end
    end
  endfunction
  function [1:0] pol_of;
    input [11:0] pv;
    input [2:0]  idx;
    begin
      pol_of = pv[idx*2 +: 2];
    end
  endfunction
  // lowest-risk policy among active faults governs
  reg [1:0] gov_pol;
  reg [2:0] nf;
  reg       any_auto;
  integer   i;
  integer   j;
  always @* begin
    gov_pol = `FRR_POL_AUTO;
    nf = 3'd0;
    any_auto = 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      if (pol_of(policy_q, i[2:0]) == `FRR_POL_AUTO) begin
        any_auto = 1'b1;
      end
      if (fault_in[i]) begin
        nf = nf + 3'd1;
        if (pol_of(policy_q, i[2:0]) < gov_pol) begin
          gov_pol = pol_of(policy_q, i[2:0]);
        end
      end
    end
  end
  wire fault_clear = ~any_fault & (|fault_prev_q);
  wire warn_evt = any_auto & ((fault_clear & ~latched_q) | out_on_req | setpoint_exit);
  // whole word is range-checked so stray upper bits cannot alias a legal delay
  wire delay_ok = (pwdata >= {24'h000000, `FRR_DELAY_MIN}) &&
                  (pwdata <= {23'h000000, `FRR_DELAY_MAX});
  frr_nvstore #(
    .AW (2),
    .DW (32)
  ) u_nv (
    .pclk  (pclk),
    .we    (nv_we),
    .waddr (nv_waddr),
    .wdata (nv_wdata),
    .raddr (rd_idx_q),
    .rdata (nv_rdata)
  );
  always @* begin
    nv_we = 1'b0;
    nv_waddr = 2'd0;
    nv_wdata = 32'h00000000;
    if (st_q == ST_RUN) begin
      nv_we = 1'b1;
      nv_waddr = 2'd0;
      nv_wdata = {12'h000, policy_q, 2'b00, inh_pol_q, fast_boot_q, trig_q, relay_mode_q};
      // own slot toggle: the dwell timer sits at zero while idle
      if (nv_slot_q) begin
        nv_waddr = 2'd1;
        nv_wdata = {23'h000000, delay_q};
      end
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= ST_BOOT;
      rd_idx_q <= 2'd0;
      relay_mode_q <= `FRR_MODE_FAULT;
      trig_q <= `FRR_TRIG_FAULT_ONLY_TRIGGER;
      delay_q <= `FRR_DELAY_DEF;
      fast_boot_q <= 1'b0;
      inh_pol_q <= 1'b1;
      policy_q <= `FRR_POLICY_DEF;
      panel_relay_q <= 1'b0;
      seq_relay_q <= 1'b0;
      trip_q <= 1'b0;
      prev_cc_q <= 1'b0;
      dwell_q <= 1'b0;
      tick_q <= 24'h000000;
      halves_q <= 9'h000;
      latched_q <= 1'b0;
      auto_pend_q <= 1'b0;
      fault_prev_q <= 6'h00;
      warn_cnt_q <= 24'h000000;
      multi_q <= 1'b0;
      nv_slot_q <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      relay_on <= 1'b0;
      output_enable <= 1'b0;
      setpoint_mode <= 1'b1;
      load_min <= 1'b0;
      load_setpoint <= 1'b0;
      load_last_actual <= 1'b0;
      auto_warning <= 1'b0;
      err_push <= 1'b0;
      err_code <= 16'h0000;
      display_code <= 12'h000;
    end else begin
      err_push <= 1'b0;
      load_min <= 1'b0;
      load_setpoint <= 1'b0;
      load_last_actual <= 1'b0;
      fault_prev_q <= fault_in;
      prev_cc_q <= cc_mode;
      case (st_q)
        ST_BOOT: begin
          rd_idx_q <= 2'd1;
          st_q <= ST_LOAD;
        end
        ST_LOAD: begin
          // index 0 data arrives now, index 1 next cycle
          if (rd_idx_q == 2'd1) begin
            relay_mode_q <= (nv_rdata[1:0] > `FRR_MODE_SEQ) ? `FRR_MODE_FAULT : nv_rdata[1:0];
            trig_q <= (nv_rdata[3:2] > `FRR_TRIG_C2V) ? `FRR_TRIG_FAULT_ONLY_TRIGGER : nv_rdata[3:2];
            fast_boot_q <= nv_rdata[4];
            inh_pol_q <= nv_rdata[5];
            policy_q <= nv_rdata[19:8];
            rd_idx_q <= 2'd2;
            setpoint_mode <= 1'b1;
            load_min <= 1'b1;
            if (pol_of(nv_rdata[19:8], 3'd4) == `FRR_POL_AUTO) begin
              warn_cnt_q <= WARN_CYC[23:0];
            end
          end else begin
            if (nv_rdata[8:0] >= {1'b0, `FRR_DELAY_MIN} && nv_rdata[8:0] <= `FRR_DELAY_MAX) begin
              delay_q <= nv_rdata[8:0];
            end
            st_q <= ST_RUN;
          end
        end
        default: begin
          tick_q <= tick_q + 24'h000001;
          nv_slot_q <= ~nv_slot_q;
        end
      endcase
      // bus slave: one wait state, answer registered
      pready <= 1'b0;
      pslverr <= 1'b0;
      if (acc & ~pready) begin
        pready <= 1'b1;
        prdata <= 32'h00000000;
        if (paddr == `FRR_ADDR_CTRL) begin
          prdata <= {26'h0, inh_pol_q, fast_boot_q, trig_q, relay_mode_q};
          if (wr) begin
            relay_mode_q <= (pwdata[1:0] > `FRR_MODE_SEQ) ? relay_mode_q : pwdata[1:0];
            trig_q <= (pwdata[3:2] > `FRR_TRIG_C2V) ? trig_q : pwdata[3:2];
            fast_boot_q <= pwdata[4];
            if (password_ok) begin
              inh_pol_q <= pwdata[5];
            end
          end
        end else if (paddr == `FRR_ADDR_DELAY) begin
          prdata <= {23'h0, delay_q};
          if (wr) begin
            if (delay_ok) begin
              delay_q <= pwdata[8:0];
            end else begin
              pslverr <= 1'b1;
            end
          end
        end else if (paddr == `FRR_ADDR_POLICY) begin
          prdata <= {20'h0, policy_q};
          if (wr & password_ok) begin
            for (j = 0; j < 6; j = j + 1) begin
              policy_q[j*2 +: 2] <= legal_pol(pwdata[j*2 +: 2], j[2:0]);
            end
          end else if (wr) begin
            pslverr <= 1'b1;
          end
        end else if (paddr == `FRR_ADDR_CMD) begin
          if (wr & pwdata[0]) begin
            panel_relay_q <= pwdata[1];
          end
        end else if (paddr == `FRR_ADDR_STATUS) begin
          prdata <= {24'h0, multi_q, latched_q, dwell_q, trip_q, auto_warning,
                     setpoint_mode, output_enable, relay_on};
        end else if (paddr == `FRR_ADDR_CODE) begin
          prdata <= {20'h0, display_code};
        end else begin
          pslverr <= 1'b1;
        end
      end
      if (security_clear) begin
        relay_mode_q <= `FRR_MODE_FAULT;
        trig_q <= `FRR_TRIG_FAULT_ONLY_TRIGGER;
      end
      if (seq_relay_cmd) begin
        seq_relay_q <= seq_relay_val;
      end
      // dwell timer in half-second ticks
      if (!trans_trig || !in_target || trip_q) begin
        dwell_q <= 1'b0;
        halves_q <= 9'h000;
        tick_q <= 24'h000000;
      end else if (!dwell_q) begin
        if (prev_cc_q != cc_mode) begin
          dwell_q <= 1'b1; // entry from the other mode only
          tick_q <= 24'h000000;
        end
      end else if (tick_q >= HALF_CYC[23:0] - 24'h000001) begin
        tick_q <= 24'h000000;
        if (halves_q + 9'h001 >= delay_q) begin
          trip_q <= 1'b1;
          err_push <= 1'b1;
          err_code <= `FRR_CODE_REG;
          display_code <= `FRR_CODE_SHOW;
          dwell_q <= 1'b0;
        end else begin
          halves_q <= halves_q + 9'h001;
        end
      end
      if (prev_cc_q != cc_mode && dwell_q) begin
        dwell_q <= 1'b0;
        halves_q <= 9'h000;
      end
      if (trip_q && (!in_target || !output_enable)) begin
        trip_q <= 1'b0;
        display_code <= 12'h000;
      end
      if (relay_mode_q != `FRR_MODE_FAULT) begin
        trip_q <= 1'b0;
      end
      // relay output by mode
      if (relay_mode_q == `FRR_MODE_PANEL) begin
        relay_on <= panel_relay_q;
      end else if (relay_mode_q == `FRR_MODE_SEQ) begin
        relay_on <= seq_relay_q;
      end else begin
        relay_on <= sys_error | (trans_trig & trip_q);
      end
      // fault response
      if (any_fault) begin
        output_enable <= 1'b0;
        if (nf > 3'd1) begin
          multi_q <= 1'b1;
        end
        if (gov_pol == `FRR_POL_PROTECTED_RECOVERY) begin
          latched_q <= 1'b1;
        end else if (gov_pol == `FRR_POL_SAFE && !setpoint_mode) begin
          setpoint_mode <= 1'b1;
          load_setpoint <= 1'b1;
        end else if (gov_pol == `FRR_POL_AUTO) begin
          auto_pend_q <= ~multi_q & (nf == 3'd1);
        end
      end else if (fault_clear && auto_pend_q && !latched_q && !multi_q) begin
        output_enable <= ~inh_active;
        load_last_actual <= 1'b1;
        auto_pend_q <= 1'b0;
      end else begin
        auto_pend_q <= 1'b0;
        if (fault_clear) begin
          multi_q <= 1'b0;
        end
        if (setpoint_exit) begin
          setpoint_mode <= 1'b0;
        end
        if (out_on_req && !latched_q && !setpoint_mode && !inh_active) begin
          output_enable <= 1'b1;
        end
        // inhibit release alone never re-enables: only out_on_req or an auto recovery on fault clear does
        if (inh_active) begin
          output_enable <= 1'b0;
        end
      end
      if (warn_evt) begin
        warn_cnt_q <= BRIEF_CYC[23:0];
      end else if (warn_cnt_q != 24'h000000) begin
        warn_cnt_q <= warn_cnt_q - 24'h000001;
      end
      auto_warning <= (warn_cnt_q != 24'h000000);
    end
  end
endmodule // frr_ctrl

// >>> hw/frr_defs.vh
`ifndef FRR_DEFS_VH
`define FRR_DEFS_VH
`define FRR_ADDR_CTRL      12'h000
`define FRR_ADDR_DELAY     12'h004
`define FRR_ADDR_POLICY    12'h008
`define FRR_ADDR_CMD       12'h00C
`define FRR_ADDR_STATUS    12'h010
`define FRR_ADDR_CODE      12'h014
`define FRR_MODE_FAULT     2'h0
`define FRR_MODE_PANEL     2'h1
`define FRR_MODE_SEQ       2'h2
`define FRR_TRIG_FAULT_ONLY_TRIGGER      2'h0
`define FRR_TRIG_V2C       2'h1
`define FRR_TRIG_C2V       2'h2
`define FRR_POL_PROTECTED_RECOVERY       2'h0
`define FRR_POL_SAFE       2'h1
`define FRR_POL_AUTO       2'h2
`define FRR_DELAY_MIN      8'h01
`define FRR_DELAY_MAX      9'h100
`define FRR_DELAY_DEF      9'h002
`define FRR_POLICY_DEF     12'h000
`define FRR_CODE_REG       16'hFED2
`define FRR_CODE_SHOW      12'h302
`define FRR_HALF_S_MS      500
`define FRR_WARN_MS        1000
`define FRR_CLK_HZ         10000000
`define FRR_NV_WORDS       4
`endif

// >>> hw/frr_nvstore.v
`timescale 1ns/1ns
// small settings store, survives presetn; registered read
module frr_nvstore #(
  parameter AW = 2,
  parameter DW = 32
) (
  input  wire          pclk,
  input  wire          we,
  input  wire [AW-1:0] waddr,
  input  wire [DW-1:0] wdata,
  input  wire [AW-1:0] raddr,
  output reg  [DW-1:0] rdata
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // frr_nvstore
